// ===== pin_bank_checker.sv
// assertions on the port pin control bank top-level ports
`timescale 1ns/10ps
module pin_bank_checker (
    input  wire logic        i_sys_clk,      // system clock
    input  wire logic        i_rst,          // synchronous reset
    input  wire logic [15:0] i_addr,         // register address
    input  wire logic        i_wr,           // write strobe
    input  wire logic        i_rd,           // read strobe
    input  wire logic [7:0]  o_rdata,        // read data
    input  wire logic        o_rd_valid,     // read data valid
    input  wire logic [7:0]  o_p8_out,       // port 8 pad level
    input  wire logic [7:0]  o_p8_oe,        // port 8 pad enable
    input  wire logic [3:0]  o_seg_sel7,     // port 7 segment bits
    input  wire logic [7:0]  o_seg_sel8,     // port 8 segment bits
    input  wire logic [7:0]  o_dir_bank0,    // port 0 direction
    input  wire logic [7:0]  o_pullup_en0,   // port 0 pull-up connect
    input  wire logic [7:0]  i_alt_out_act0  // port 0 alternate outputs
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // reads of the port data registers
    sequence rd_p8;
        i_rd && i_addr == port_bank_pkg::ADDR_P8;
    endsequence
    sequence rd_p7;
        i_rd && i_addr == port_bank_pkg::ADDR_P7;
    endsequence

    a_rd_valid_time: assert property (o_rd_valid == $past(i_rd))
        else $error("read valid not one cycle after read strobe");
    a_out_read_latch: assert property (rd_p8 |=> ((o_rdata ^ $past(o_p8_out)) & $past(o_p8_oe)) == 8'h00)
        else $error("output-mode bit did not read back the latch");
    a_seg_read_zero: assert property (rd_p8 |=> (o_rdata & $past(o_seg_sel8)) == 8'h00)
        else $error("segment bit of port 8 read non-zero");
    a_p7_read_mask: assert property (rd_p7 |=> o_rdata[7:4] == 4'h0 && (o_rdata[3:0] & $past(o_seg_sel7)) == 4'h0)
        else $error("port 7 read shows a segment or missing bit");
    a_seg_no_drive: assert property (((o_p8_out | o_p8_oe) & o_seg_sel8) == 8'h00)
        else $error("segment pin driven by the port latch");
    a_latch_hold: assert property (!(i_wr && (i_addr == port_bank_pkg::ADDR_P8 || i_addr == port_bank_pkg::ADDR_SEG8)) |=> $stable(o_p8_out))
        else $error("port 8 output changed without a write");
    a_func_wr_only: assert property (i_rd && i_addr == port_bank_pkg::ADDR_SEG8 |=> o_rdata == 8'h00)
        else $error("function register read non-zero");
    a_pullup_out_off: assert property ((o_pullup_en0 & ~$past(o_dir_bank0)) == 8'h00)
        else $error("pull-up on an output-mode pin");
    a_pullup_alt_off: assert property ((o_pullup_en0 & $past(i_alt_out_act0)) == 8'h00)
        else $error("pull-up on an alternate-output pin");
    a_reset_state: assert property ($past(i_rst) |-> o_dir_bank0 == 8'hff && o_seg_sel8 == 8'h00 && o_p8_oe == 8'h00 && o_pullup_en0 == 8'h00)
        else $error("register not at reset value after reset");
endmodule : pin_bank_checker

// ===== pin_env_model.sv
// pin-side circuitry model: drives ports 6 to 8 and resolves the port 8 wire
`timescale 1ns/10ps
module pin_env_model (
    input  wire logic       i_sys_clk,   // system clock
    input  wire logic [7:0] i_p6_drv,    // level applied to port 6
    input  wire logic [3:0] i_p7_drv,    // level applied to port 7
    input  wire logic [7:0] i_p8_drv,    // level applied to port 8
    input  wire logic [7:0] i_p8_drv_en, // port 8 bits the circuit drives
    input  wire logic [7:0] i_p8_out,    // device pad level
    input  wire logic [7:0] i_p8_oe,     // device pad enable
    output logic      [7:0] o_p6_pin,    // port 6 wire
    output logic      [3:0] o_p7_pin,    // port 7 wire
    output logic      [7:0] o_p8_pin     // port 8 wire
);
    logic [7:0] float_r = 8'h5a; // level an undriven wire wanders to
    // input-only ports see the circuit directly
    assign o_p6_pin = i_p6_drv;
    assign o_p7_pin = i_p7_drv;
    // device driver where enabled, else circuit, else a wandering level
    assign o_p8_pin = (i_p8_oe & i_p8_out) | (~i_p8_oe & i_p8_drv_en & i_p8_drv)
                    | (~i_p8_oe & ~i_p8_drv_en & float_r);
    // undriven bits flip every cycle so a stale value never reads as good
    always_ff @(posedge i_sys_clk) begin
        float_r <= ~o_p8_pin;
    end
endmodule : pin_env_model

// ===== pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         i_sys_clk, // system clock
    input  wire logic         i_rst,     // synchronous reset
    input  wire logic [W-1:0] i_d,       // asynchronous pin levels
    output logic      [W-1:0] o_q        // accepted levels
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // shift chain; the first stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // take each bit only where the last two stages agree
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_q <= '0;
        end else begin
            o_q <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & o_q);
        end
    end
endmodule : pin_sync

// ===== port8_if.sv
// bundle between the bank and the bidirectional port slice
`timescale 1ns/10ps
interface port8_if;
    logic [7:0] latch;   // output latch
    logic [7:0] dir;     // direction, 1 = input
    logic [7:0] seg;     // 1 = segment output
    logic [7:0] pin;     // synchronised pin level
    logic [7:0] rd_val;  // value a port read returns
    logic [7:0] pad_out; // pad output level
    logic [7:0] pad_oe;  // pad output enable

    modport ctrl  (output latch, dir, seg, pin, input rd_val, pad_out, pad_oe);
    modport slice (input latch, dir, seg, pin, output rd_val, pad_out, pad_oe);
endinterface : port8_if

// ===== port8_slice.sv
// per-bit pad control and read-back of the bidirectional port
`timescale 1ns/10ps
module port8_slice (
    port8_if.slice pif // bank side bundle
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            // driver on only for port bits in output mode
            assign pif.pad_oe[i]  = ~pif.dir[i] & ~pif.seg[i];
            assign pif.pad_out[i] = pif.latch[i] & ~pif.seg[i];
            // output mode reads the latch, input mode the pin
            assign pif.rd_val[i]  = pif.seg[i] ? 1'b0 :
                                    (pif.dir[i] ? pif.pin[i] : pif.latch[i]);
        end
    endgenerate
endmodule : port8_slice

// ===== port_bank_pkg.sv
// constants, register map and types for the port pin control bank
package port_bank_pkg;

    // register addresses on the internal bus
    localparam logic [15:0] ADDR_P6   = 16'hff06;
    localparam logic [15:0] ADDR_P7   = 16'hff07;
    localparam logic [15:0] ADDR_P8   = 16'hff08;
    localparam logic [15:0] ADDR_DIR0 = 16'hff20;
    localparam logic [15:0] ADDR_DIR1 = 16'hff21;
    localparam logic [15:0] ADDR_DIR2 = 16'hff22;
    localparam logic [15:0] ADDR_DIR3 = 16'hff23;
    localparam logic [15:0] ADDR_DIR5 = 16'hff25;
    localparam logic [15:0] ADDR_DIR8 = 16'hff28;
    localparam logic [15:0] ADDR_PULLUP_SEL0 = 16'hff30;
    localparam logic [15:0] ADDR_PULLUP_SEL1 = 16'hff31;
    localparam logic [15:0] ADDR_PULLUP_SEL2 = 16'hff32;
    localparam logic [15:0] ADDR_PULLUP_SEL3 = 16'hff33;
    localparam logic [15:0] ADDR_SEG7 = 16'hff57;
    localparam logic [15:0] ADDR_SEG8 = 16'hff58;

    // reset values
    localparam logic [7:0] DIR_RST   = 8'hff;
    localparam logic [7:0] PUB_RST   = 8'h00;
    localparam logic [7:0] SEG_RST   = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;

    // implemented bits; missing direction bits read 1, others read 0
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_P1   = 8'h03;
    localparam logic [7:0] MASK_P2   = 8'h3f;
    localparam logic [7:0] MASK_P3   = 8'h1f;
    localparam logic [7:0] MASK_P5   = 8'h0f;
    localparam logic [7:0] MASK_P7   = 8'h0f;

    // register selected by an address
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_P6   = 4'h1,
        SEL_P7   = 4'h2,
        SEL_P8   = 4'h3,
        SEL_DIR0 = 4'h4,
        SEL_DIR1 = 4'h5,
        SEL_DIR2 = 4'h6,
        SEL_DIR3 = 4'h7,
        SEL_DIR5 = 4'h8,
        SEL_DIR8 = 4'h9,
        SEL_PULLUP_SEL0 = 4'ha,
        SEL_PULLUP_SEL1 = 4'hb,
        SEL_PULLUP_SEL2 = 4'hc,
        SEL_PULLUP_SEL3 = 4'hd,
        SEL_SEG7 = 4'he,
        SEL_SEG8 = 4'hf
    } reg_sel_t;

endpackage : port_bank_pkg

// ===== port_pin_control_bank.sv
// port pin control bank: direction, pull-up and port/segment registers, ports 6 to 8
//
// Operation
// - port 6 eight input-only pins, read levels
// - port 7 four inputs, port bits only
// - port 8 eight bidirectional, reset input mode
// - port 8 bit acts only when port-selected
// - direction 0 output driver on, 1 input
// - direction registers byte/bit writable, reset ones
// - pull-up only when selected and input mode
// - output mode or alternate output drops pull-up
// - pull-up select 1 connects, reset zeros
// - function bit 0 port, 1 segment, reset clear
// - function registers write-only, byte writes only
// - fixed-function variant ignores function register writes
// - output mode write loads and holds latch
// - input mode write updates latch, pin unchanged
// - bit operation is byte read-modify-write
// - output mode read returns latch, unchanged
// - input mode read returns pin, latch unchanged
`timescale 1ns/10ps
module port_pin_control_bank #(
    parameter bit         FUNC_FIXED = 1'b0,  // 1 = pin function fixed at manufacture
    parameter logic [7:0] FIXED_SEG7 = 8'h00, // fixed port 7 function bits
    parameter logic [7:0] FIXED_SEG8 = 8'h00  // fixed port 8 function bits
) (
    input  wire logic        i_sys_clk,      // system clock, 10 MHz
    input  wire logic        i_rst,          // synchronous reset, active high
    input  wire logic [15:0] i_addr,         // register address
    input  wire logic        i_wr,           // write strobe
    input  wire logic        i_rd,           // read strobe
    input  wire logic        i_bit_op,       // write is a single-bit operation
    input  wire logic [2:0]  i_bit_idx,      // bit number for a bit operation
    input  wire logic        i_bit_val,      // bit value for a bit operation
    input  wire logic [7:0]  i_wdata,        // byte write data
    output logic      [7:0]  o_rdata,        // read data, registered
    output logic             o_rd_valid,     // read data valid pulse
    input  wire logic [7:0]  i_p6_pin,       // port 6 pins
    input  wire logic [3:0]  i_p7_pin,       // port 7 pins
    input  wire logic [7:0]  i_p8_pin,       // port 8 pin input
    output logic      [7:0]  o_p8_out,       // port 8 pin output
    output logic      [7:0]  o_p8_oe,        // port 8 pin output enable
    output logic      [7:0]  o_p6_level,     // port 6 levels to analog and key logic
    output logic      [7:0]  o_dir_bank0,    // port 0 direction
    output logic      [7:0]  o_dir_bank1,    // port 1 direction
    output logic      [7:0]  o_dir_bank2,    // port 2 direction
    output logic      [7:0]  o_dir_bank3,    // port 3 direction
    output logic      [7:0]  o_dir_bank5,    // port 5 direction
    input  wire logic [7:0]  i_alt_out_act0, // port 0 bits driven by alternate output
    input  wire logic [7:0]  i_alt_out_act1, // port 1 bits driven by alternate output
    input  wire logic [7:0]  i_alt_out_act2, // port 2 bits driven by alternate output
    input  wire logic [7:0]  i_alt_out_act3, // port 3 bits driven by alternate output
    output logic      [7:0]  o_pullup_en0,   // port 0 pull-up connect
    output logic      [7:0]  o_pullup_en1,   // port 1 pull-up connect
    output logic      [7:0]  o_pullup_en2,   // port 2 pull-up connect
    output logic      [7:0]  o_pullup_en3,   // port 3 pull-up connect
    output logic      [3:0]  o_seg_sel7,     // port 7 bits given to segment output
    output logic      [7:0]  o_seg_sel8      // port 8 bits given to segment output
);

    // address decode, shared by read and write paths
    function automatic port_bank_pkg::reg_sel_t decode(input logic [15:0] a);
        unique case (a)
            port_bank_pkg::ADDR_P6:   decode = port_bank_pkg::SEL_P6;
            port_bank_pkg::ADDR_P7:   decode = port_bank_pkg::SEL_P7;
            port_bank_pkg::ADDR_P8:   decode = port_bank_pkg::SEL_P8;
            port_bank_pkg::ADDR_DIR0: decode = port_bank_pkg::SEL_DIR0;
            port_bank_pkg::ADDR_DIR1: decode = port_bank_pkg::SEL_DIR1;
            port_bank_pkg::ADDR_DIR2: decode = port_bank_pkg::SEL_DIR2;
            port_bank_pkg::ADDR_DIR3: decode = port_bank_pkg::SEL_DIR3;
            port_bank_pkg::ADDR_DIR5: decode = port_bank_pkg::SEL_DIR5;
            port_bank_pkg::ADDR_DIR8: decode = port_bank_pkg::SEL_DIR8;
            port_bank_pkg::ADDR_PULLUP_SEL0: decode = port_bank_pkg::SEL_PULLUP_SEL0;
            port_bank_pkg::ADDR_PULLUP_SEL1: decode = port_bank_pkg::SEL_PULLUP_SEL1;
            port_bank_pkg::ADDR_PULLUP_SEL2: decode = port_bank_pkg::SEL_PULLUP_SEL2;
            port_bank_pkg::ADDR_PULLUP_SEL3: decode = port_bank_pkg::SEL_PULLUP_SEL3;
            port_bank_pkg::ADDR_SEG7: decode = port_bank_pkg::SEL_SEG7;
            port_bank_pkg::ADDR_SEG8: decode = port_bank_pkg::SEL_SEG8;
            default:                  decode = port_bank_pkg::SEL_NONE;
        endcase
    endfunction : decode

    // direction value with unimplemented bits held at 1
    function automatic logic [7:0] dir_fix(input logic [7:0] v, input logic [7:0] m);
        dir_fix = (v & m) | ~m;
    endfunction : dir_fix

    port_bank_pkg::reg_sel_t sel;
    logic [7:0] dir0_r;
    logic [7:0] dir1_r;
    logic [7:0] dir2_r;
    logic [7:0] dir3_r;
    logic [7:0] dir5_r;
    logic [7:0] dir8_r;
    logic [7:0] pullup_sel0_r;
    logic [7:0] pullup_sel1_r;
    logic [7:0] pullup_sel2_r;
    logic [7:0] pullup_sel3_r;
    logic [7:0] seg7_r;
    logic [7:0] seg8_r;
    logic [7:0] latch8_r;
    logic [7:0] seg7_eff;
    logic [7:0] seg8_eff;
    logic [7:0] p6_sync;
    logic [3:0] p7_sync;
    logic [7:0] p8_sync;
    logic [7:0] p7_rd;
    logic [7:0] rd_cur;
    logic [7:0] wval;
    logic       wr_byte;

    port8_if pif ();

    // pin synchronisers for the input levels
    pin_sync #(.W(8)) u_sync6 (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_d       (i_p6_pin),
        .o_q       (p6_sync)
    );

    pin_sync #(.W(4)) u_sync7 (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_d       (i_p7_pin),
        .o_q       (p7_sync)
    );

    pin_sync #(.W(8)) u_sync8 (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_d       (i_p8_pin),
        .o_q       (p8_sync)
    );

    // bidirectional port pads and read-back
    port8_slice u_slice8 (
        .pif (pif.slice)
    );

    // function selection: fixed values or the written registers
    assign seg7_eff = FUNC_FIXED ? (FIXED_SEG7 & port_bank_pkg::MASK_P7) : seg7_r;
    assign seg8_eff = FUNC_FIXED ? FIXED_SEG8 : seg8_r;

    // bundle toward the port slice
    assign pif.latch = latch8_r;
    assign pif.dir   = dir8_r;
    assign pif.seg   = seg8_eff;
    assign pif.pin   = p8_sync;

    // port 7 reads pins only for port-selected bits
    assign p7_rd = {4'h0, p7_sync & ~seg7_eff[3:0]};

    assign sel     = decode(i_addr);
    assign wr_byte = i_wr & ~i_bit_op;

    // current readable value of the addressed register
    always_comb begin
        unique case (sel)
            port_bank_pkg::SEL_P6:   rd_cur = p6_sync;
            port_bank_pkg::SEL_P7:   rd_cur = p7_rd;
            port_bank_pkg::SEL_P8:   rd_cur = pif.rd_val;
            port_bank_pkg::SEL_DIR0: rd_cur = dir0_r;
            port_bank_pkg::SEL_DIR1: rd_cur = dir1_r;
            port_bank_pkg::SEL_DIR2: rd_cur = dir2_r;
            port_bank_pkg::SEL_DIR3: rd_cur = dir3_r;
            port_bank_pkg::SEL_DIR5: rd_cur = dir5_r;
            port_bank_pkg::SEL_DIR8: rd_cur = dir8_r;
            port_bank_pkg::SEL_PULLUP_SEL0: rd_cur = pullup_sel0_r;
            port_bank_pkg::SEL_PULLUP_SEL1: rd_cur = pullup_sel1_r;
            port_bank_pkg::SEL_PULLUP_SEL2: rd_cur = pullup_sel2_r;
            port_bank_pkg::SEL_PULLUP_SEL3: rd_cur = pullup_sel3_r;
            port_bank_pkg::SEL_SEG7: rd_cur = 8'h00;
            port_bank_pkg::SEL_SEG8: rd_cur = 8'h00;
            port_bank_pkg::SEL_NONE: rd_cur = 8'h00;
        endcase
    end

    // write value: a bit operation reads the whole byte and writes it back
    always_comb begin
        wval = i_wdata;
        if (i_bit_op) begin
            wval = rd_cur;
            wval[i_bit_idx] = i_bit_val;
        end
    end

    // direction registers, byte or bit writes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            dir0_r <= port_bank_pkg::DIR_RST;
            dir1_r <= port_bank_pkg::DIR_RST;
            dir2_r <= port_bank_pkg::DIR_RST;
            dir3_r <= port_bank_pkg::DIR_RST;
            dir5_r <= port_bank_pkg::DIR_RST;
            dir8_r <= port_bank_pkg::DIR_RST;
        end else if (i_wr) begin
            if (sel == port_bank_pkg::SEL_DIR0) begin
                dir0_r <= dir_fix(wval, port_bank_pkg::MASK_FULL);
            end
            if (sel == port_bank_pkg::SEL_DIR1) begin
                dir1_r <= dir_fix(wval, port_bank_pkg::MASK_P1);
            end
            if (sel == port_bank_pkg::SEL_DIR2) begin
                dir2_r <= dir_fix(wval, port_bank_pkg::MASK_P2);
            end
            if (sel == port_bank_pkg::SEL_DIR3) begin
                dir3_r <= dir_fix(wval, port_bank_pkg::MASK_P3);
            end
            if (sel == port_bank_pkg::SEL_DIR5) begin
                dir5_r <= dir_fix(wval, port_bank_pkg::MASK_P5);
            end
            if (sel == port_bank_pkg::SEL_DIR8) begin
                dir8_r <= wval;
            end
        end
    end

    // pull-up select registers, byte or bit writes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pullup_sel0_r <= port_bank_pkg::PUB_RST;
            pullup_sel1_r <= port_bank_pkg::PUB_RST;
            pullup_sel2_r <= port_bank_pkg::PUB_RST;
            pullup_sel3_r <= port_bank_pkg::PUB_RST;
        end else if (i_wr) begin
            if (sel == port_bank_pkg::SEL_PULLUP_SEL0) begin
                pullup_sel0_r <= wval;
            end
            if (sel == port_bank_pkg::SEL_PULLUP_SEL1) begin
                pullup_sel1_r <= wval & port_bank_pkg::MASK_P1;
            end
            if (sel == port_bank_pkg::SEL_PULLUP_SEL2) begin
                pullup_sel2_r <= wval & port_bank_pkg::MASK_P2;
            end
            if (sel == port_bank_pkg::SEL_PULLUP_SEL3) begin
                pullup_sel3_r <= wval & port_bank_pkg::MASK_P3;
            end
        end
    end

    // port/segment function registers: byte writes only, ignored when fixed
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            seg7_r <= port_bank_pkg::SEG_RST;
            seg8_r <= port_bank_pkg::SEG_RST;
        end else if (wr_byte && !FUNC_FIXED) begin
            if (sel == port_bank_pkg::SEL_SEG7) begin
                seg7_r <= i_wdata & port_bank_pkg::MASK_P7;
            end
            if (sel == port_bank_pkg::SEL_SEG8) begin
                seg8_r <= i_wdata;
            end
        end
    end

    // port 8 output latch: any write loads all eight bits and holds them
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            latch8_r <= port_bank_pkg::LATCH_RST;
        end else if (i_wr && sel == port_bank_pkg::SEL_P8) begin
            latch8_r <= wval;
        end
    end

    // registered read data; reads have no side effect
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata    <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd;
            if (i_rd) begin
                o_rdata <= rd_cur;
            end
        end
    end

    // pull-ups only on selected input-mode pins not used as alternate output
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pullup_en0 <= 8'h00;
            o_pullup_en1 <= 8'h00;
            o_pullup_en2 <= 8'h00;
            o_pullup_en3 <= 8'h00;
        end else begin
            o_pullup_en0 <= pullup_sel0_r & dir0_r & ~i_alt_out_act0;
            o_pullup_en1 <= pullup_sel1_r & dir1_r & ~i_alt_out_act1;
            o_pullup_en2 <= pullup_sel2_r & dir2_r & ~i_alt_out_act2;
            o_pullup_en3 <= pullup_sel3_r & dir3_r & ~i_alt_out_act3;
        end
    end

    // pads and status toward the rest of the chip
    assign o_p8_out    = pif.pad_out;
    assign o_p8_oe     = pif.pad_oe;
    assign o_p6_level  = p6_sync;
    assign o_dir_bank0 = dir0_r;
    assign o_dir_bank1 = dir1_r;
    assign o_dir_bank2 = dir2_r;
    assign o_dir_bank3 = dir3_r;
    assign o_dir_bank5 = dir5_r;
    assign o_seg_sel7  = seg7_eff[3:0];
    assign o_seg_sel8  = seg8_eff;

endmodule : port_pin_control_bank

// ===== port_pin_control_bank_tb.sv
// self-checking bench for the port pin control bank
`timescale 1ns/10ps
module port_pin_control_bank_tb;
    typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r0; logic [7:0] r1;} row_t;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [15:0] i_addr = 16'h0000;
    logic        i_wr = 1'b0, i_rd = 1'b0, i_bit_op = 1'b0, i_bit_val = 1'b0;
    logic [2:0]  i_bit_idx = 3'h0;
    logic [7:0]  i_wdata = 8'h00, alt0 = 8'h00, p6_drv = 8'h96, dir3, dir5;
    logic [7:0]  p8_drv = 8'h00, p8_drv_en = 8'h00, p6_pin, p8_pin, fx_seg8, dir1, dir2;
    logic [3:0]  p7_drv = 4'hf, p7_pin, o_seg_sel7, fx_seg7;
    logic [7:0]  o_rdata, o_p8_out, o_p8_oe, o_p6_level, o_seg_sel8, dir0, pu0, pu3, pu1, pu2;
    logic        o_rd_valid;
    int          mismatches = 0;
    int          total_checks = 0;
    // address, write data, reset read-back, read-back after the write
    row_t rows [13] = '{
        '{16'hff20, 8'h55, 8'hff, 8'h55}, '{16'hff21, 8'h00, 8'hff, 8'hfc},
        // ports 2 and 3 go to output mode; their unimplemented direction bits stay set
        '{16'hff22, 8'h00, 8'hff, 8'hc0}, '{16'hff23, 8'h00, 8'hff, 8'he0},
        '{16'hff25, 8'h00, 8'hff, 8'hf0}, '{16'hff28, 8'hff, 8'hff, 8'hff},
        '{16'hff30, 8'hff, 8'h00, 8'hff}, '{16'hff31, 8'hff, 8'h00, 8'h03},
        '{16'hff32, 8'hff, 8'h00, 8'h3f}, '{16'hff33, 8'hff, 8'h00, 8'h1f},
        '{16'hff57, 8'h0f, 8'h00, 8'h00}, '{16'hff58, 8'h00, 8'h00, 8'h00},
        '{16'hff10, 8'hff, 8'h00, 8'h00}};

    pin_env_model u_env (.i_sys_clk(i_sys_clk), .i_p6_drv(p6_drv), .i_p7_drv(p7_drv),
        .i_p8_drv(p8_drv), .i_p8_drv_en(p8_drv_en), .i_p8_out(o_p8_out), .i_p8_oe(o_p8_oe),
        .o_p6_pin(p6_pin), .o_p7_pin(p7_pin), .o_p8_pin(p8_pin));
    port_pin_control_bank u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr(i_wr), .i_rd(i_rd), .i_bit_op(i_bit_op), .i_bit_idx(i_bit_idx),
        .i_bit_val(i_bit_val), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .i_p6_pin(p6_pin), .i_p7_pin(p7_pin), .i_p8_pin(p8_pin), .o_p8_out(o_p8_out),
        .o_p8_oe(o_p8_oe), .o_p6_level(o_p6_level), .o_dir_bank0(dir0), .o_dir_bank1(dir1),
        .o_dir_bank2(dir2), .o_dir_bank3(dir3), .o_dir_bank5(dir5), .i_alt_out_act0(alt0),
        .i_alt_out_act1(alt0), .i_alt_out_act2(alt0), .i_alt_out_act3(alt0),
        .o_pullup_en0(pu0), .o_pullup_en1(pu1), .o_pullup_en2(pu2), .o_pullup_en3(pu3),
        .o_seg_sel7(o_seg_sel7), .o_seg_sel8(o_seg_sel8));
    port_pin_control_bank #(.FUNC_FIXED(1'b1), .FIXED_SEG7(8'h03)) u_fix (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
        .i_bit_op(i_bit_op), .i_bit_idx(i_bit_idx), .i_bit_val(i_bit_val), .i_wdata(i_wdata),
        .o_rdata(), .o_rd_valid(), .i_p6_pin(p6_pin), .i_p7_pin(p7_pin), .i_p8_pin(p8_pin),
        .o_p8_out(), .o_p8_oe(), .o_p6_level(), .o_dir_bank0(), .o_dir_bank1(), .o_dir_bank2(),
        .o_dir_bank3(), .o_dir_bank5(), .i_alt_out_act0(alt0), .i_alt_out_act1(alt0),
        .i_alt_out_act2(alt0), .i_alt_out_act3(alt0), .o_pullup_en0(), .o_pullup_en1(),
        .o_pullup_en2(), .o_pullup_en3(), .o_seg_sel7(fx_seg7), .o_seg_sel8(fx_seg8));

    // clock generator, 100 ns period
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : cyc

    // one write strobe; bit operations carry index and value
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
                      input logic [2:0] idx = 3'h0, input logic bv = 1'b0);
        cyc(1);
        i_addr = a;
        i_wdata = d;
        i_bit_op = b;
        i_bit_idx = idx;
        i_bit_val = bv;
        i_wr = 1'b1;
        cyc(1);
        i_wr = 1'b0;
        i_bit_op = 1'b0;
    endtask : wr

    // one read strobe, data taken with the valid pulse
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        cyc(1);
        i_addr = a;
        i_rd = 1'b1;
        cyc(1);
        i_rd = 1'b0;
        chk("rd_valid", {7'h00, o_rd_valid}, 8'h01);
        chk($sformatf("read %h", a), o_rdata, e);
    endtask : rdchk

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        cyc(10);
        i_rst = 1'b0;
        foreach (rows[i]) begin
            rdchk(rows[i].a, rows[i].r0);
            wr(rows[i].a, rows[i].w);
            rdchk(rows[i].a, rows[i].r1);
        end
        chk("seg7", {4'h0, o_seg_sel7}, 8'h0f);
        chk("pu0", pu0, 8'h55);
        chk("pu3", pu3, 8'h00);
        chk("pu1", pu1, 8'h00);
        chk("pu2", pu2, 8'h00);
        chk("dir1", dir1, 8'hfc);
        chk("dir2", dir2, 8'hc0);
        chk("dir3", dir3, 8'he0);
        chk("dir5", dir5, 8'hf0);
        alt0 = 8'h01;
        wr(16'hff20, 8'h00, 1'b1, 3'h0, 1'b0);
        cyc(1);
        chk("pu0 alt", pu0, 8'h54);
        wr(16'hff57, 8'h05);
        rdchk(16'hff07, 8'h0a);
        rdchk(16'hff06, 8'h96);
        chk("p6 level", o_p6_level, 8'h96);
        wr(16'hff28, 8'h00);
        wr(16'hff08, 8'ha5);
        chk("p8 out", o_p8_out, 8'ha5);
        chk("p8 oe", o_p8_oe, 8'hff);
        rdchk(16'hff08, 8'ha5);
        wr(16'hff28, 8'hff);
        p8_drv = 8'h3c;
        p8_drv_en = 8'hff;
        wr(16'hff08, 8'h0f);
        chk("p8 oe in", o_p8_oe, 8'h00);
        cyc(4);
        rdchk(16'hff08, 8'h3c);
        p8_drv_en = 8'hf0;
        wr(16'hff28, 8'hf0);
        cyc(4);
        wr(16'hff08, 8'h00, 1'b1, 3'h1, 1'b0);
        p8_drv_en = 8'h00;
        wr(16'hff28, 8'h00);
        chk("p8 rmw", o_p8_out, 8'h3d);
        wr(16'hff58, 8'h0f);
        chk("seg8", o_seg_sel8, 8'h0f);
        chk("fix seg8", fx_seg8, 8'h00);
        chk("fix seg7", {4'h0, fx_seg7}, 8'h03);
        chk("p8 seg out", o_p8_out, 8'h30);
        chk("p8 seg oe", o_p8_oe, 8'hf0);
        rdchk(16'hff08, 8'h30);
        wr(16'hff58, 8'h00, 1'b1, 3'h7, 1'b1);
        chk("seg8 bitop", o_seg_sel8, 8'h0f);
        i_rst = 1'b1;
        cyc(2);
        i_rst = 1'b0;
        chk("rst dir0", dir0, 8'hff);
        chk("rst seg8", o_seg_sel8, 8'h00);
        chk("rst oe", o_p8_oe, 8'h00);
        chk("rst pu0", pu0, 8'h00);
        test_done();
    end

    // watchdog well beyond the roughly 130 cycles the tests take
    initial begin
        #100us;
        mismatches++;
        test_done();
    end
endmodule : port_pin_control_bank_tb

bind port_pin_control_bank pin_bank_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .o_p8_out(o_p8_out), .o_p8_oe(o_p8_oe), .o_seg_sel7(o_seg_sel7), .o_seg_sel8(o_seg_sel8),
    .o_dir_bank0(o_dir_bank0), .o_pullup_en0(o_pullup_en0), .i_alt_out_act0(i_alt_out_act0));
